// file: acs_pkg.sv
package acs_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // ==========================================================
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] CFG_OFF = 8'h04;
    localparam logic [7:0] TRIG_OFF = 8'h08;
    localparam logic [7:0] RESH_OFF = 8'h0C;
    localparam logic [7:0] RESL_OFF = 8'h10;
    localparam logic [7:0] STAT_OFF = 8'h14;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int ON_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int CHS_LSB = 2;
    localparam int JUSTIFY_BIT = 7;
    localparam int FLAG_BIT = 0;
    localparam int IRQEN_BIT = 1;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [4:0] TRIG_RST = 5'h00;

    // ==========================================================
    // Trigger codes and channel codes
    // ==========================================================
    localparam logic [4:0] TRIG_NONE = 5'h00;
    localparam logic [4:0] TRIG_LAST = 5'h12;
    localparam int NUM_TRIG = 19;
    localparam logic [5:0] CH_PA_FIRST = 6'h00;
    localparam logic [5:0] CH_PA_LAST = 6'h05;
    localparam logic [5:0] CH_PA4 = 6'h04;
    localparam logic [5:0] CH_PC_FIRST = 6'h10;
    localparam logic [5:0] CH_PC_LAST = 6'h15;
    localparam logic [5:0] CH_INT_FIRST = 6'h3B;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ = 100;
    localparam int CONV_NS = 11500;
    localparam int CONV_CYC = CONV_NS * CLK_MHZ / 1000;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_CONV = 2'b01,
        ACS_DONE = 2'b10
    } acs_state_t;

    typedef struct packed {
        logic valid;
        logic [9:0] data;
    } acs_sample_t;

endpackage : acs_pkg

// file: acs_sequencer.sv
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
    parameter int CONV_CYCLES = acs_pkg::CONV_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [acs_pkg::NUM_TRIG-1:1] trig_src,
    input wire logic sleep_mode,
    input wire logic ext_osc_clock,
    input wire logic [9:0] sample_data,
    output logic converter_on,
    output logic [5:0] input_channel_select,
    output logic channel_connect,
    output logic sample_hold,
    output logic conversion_complete_flag,
    output logic conversion_irq
);

    // ==========================================================
    // Register state
    // ==========================================================
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] cfg_ff, nxt_cfg;
    logic [4:0] trig_sel_ff, nxt_trig_sel;
    logic [7:0] resh_ff, nxt_resh;
    logic [7:0] resl_ff, nxt_resl;
    logic flag_ff, nxt_flag;
    logic irqen_ff, nxt_irqen;
    acs_pkg::acs_state_t state_ff, nxt_state;
    logic [31:0] cnt_ff, nxt_cnt;
    logic awhave_ff, nxt_awhave, whave_ff, nxt_whave;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic wstrb0_ff, nxt_wstrb0;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [acs_pkg::NUM_TRIG-1:1] s1_ff, s2_ff, s3_ff;
    logic [acs_pkg::NUM_TRIG-1:1] stable_ff, nxt_stable;
    logic trig_prev_ff, nxt_trig_prev;

    // ==========================================================
    // Trigger synchronisers and selection
    // ==========================================================
    logic trig_level;
    logic trig_edge;
    genvar gi;
    generate
        for (gi = 1; gi < acs_pkg::NUM_TRIG; gi++) begin : g_sync
            // Change counts once second and third stages agree
            always_comb begin
                nxt_stable[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi] : stable_ff[gi];
            end
        end
    endgenerate

    always_comb begin
        trig_level = 1'b0;
        // Index equals the select code; zero and reserved codes pick nothing
        if (trig_sel_ff != acs_pkg::TRIG_NONE && trig_sel_ff <= acs_pkg::TRIG_LAST) begin
            trig_level = stable_ff[trig_sel_ff];
        end
        nxt_trig_prev = trig_level;
        // Sleep and busy both mask the edge; previous level still tracks
        trig_edge = trig_level && !trig_prev_ff && !sleep_mode
                    && state_ff == acs_pkg::ACS_IDLE;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            stable_ff <= '0;
            trig_prev_ff <= 1'b0;
        end else begin
            s1_ff <= trig_src;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            stable_ff <= nxt_stable;
            trig_prev_ff <= nxt_trig_prev;
        end
    end

    // ==========================================================
    // Bus decode helpers
    // ==========================================================
    logic wr_fire;
    logic rd_fire;
    logic sw_go;
    logic [9:0] sample_word;
    always_comb begin
        wr_fire = awhave_ff && whave_ff && !bvalid_ff;
        rd_fire = s_axi_arvalid && !rvalid_ff;
        sw_go = wr_fire && wstrb0_ff && awaddr_ff == acs_pkg::CTRL_OFF
                && wdata_ff[acs_pkg::GO_BIT];
        sample_word = sample_data;
    end

    // ==========================================================
    // Register file and conversion sequencer
    // ==========================================================
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_cfg = cfg_ff;
        nxt_trig_sel = trig_sel_ff;
        nxt_resh = resh_ff;
        nxt_resl = resl_ff;
        nxt_flag = flag_ff;
        nxt_irqen = irqen_ff;
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_awhave = awhave_ff || s_axi_awvalid;
        nxt_whave = whave_ff || s_axi_wvalid;
        nxt_awaddr = (!awhave_ff && s_axi_awvalid) ? s_axi_awaddr : awaddr_ff;
        nxt_wdata = (!whave_ff && s_axi_wvalid) ? s_axi_wdata : wdata_ff;
        nxt_wstrb0 = (!whave_ff && s_axi_wvalid) ? s_axi_wstrb[0] : wstrb0_ff;
        nxt_bvalid = bvalid_ff && !s_axi_bready;
        nxt_bresp = bresp_ff;
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;

        if (wr_fire) begin
            nxt_awhave = 1'b0;
            nxt_whave = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = 2'b00;
            if (wstrb0_ff) begin
                unique case (awaddr_ff)
                    acs_pkg::CTRL_OFF: begin
                        // Busy bit is set only through the start path below
                        nxt_ctrl = {wdata_ff[7:2], ctrl_ff[acs_pkg::GO_BIT],
                                    wdata_ff[acs_pkg::ON_BIT]};
                    end
                    acs_pkg::CFG_OFF: nxt_cfg = wdata_ff[7:0];
                    acs_pkg::TRIG_OFF: nxt_trig_sel = wdata_ff[4:0];
                    acs_pkg::RESH_OFF: nxt_resh = wdata_ff[7:0];
                    acs_pkg::RESL_OFF: nxt_resl = wdata_ff[7:0];
                    acs_pkg::STAT_OFF: begin
                        nxt_flag = wdata_ff[acs_pkg::FLAG_BIT];
                        nxt_irqen = wdata_ff[acs_pkg::IRQEN_BIT];
                    end
                    default: nxt_bresp = 2'b10;
                endcase
            end
        end

        unique case (state_ff)
            acs_pkg::ACS_IDLE: begin
                if ((sw_go || trig_edge) && ctrl_ff[acs_pkg::ON_BIT]) begin
                    nxt_ctrl[acs_pkg::GO_BIT] = 1'b1;
                    nxt_cnt = '0;
                    nxt_state = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV: begin
                if (!nxt_ctrl[acs_pkg::ON_BIT]) begin
                    // Disable aborts with no result
                    nxt_ctrl[acs_pkg::GO_BIT] = 1'b0;
                    nxt_state = acs_pkg::ACS_IDLE;
                end else if (cnt_ff >= CONV_CYCLES - 1) begin
                    nxt_state = acs_pkg::ACS_DONE;
                end else begin
                    nxt_cnt = cnt_ff + 32'h00000001;
                end
            end
            acs_pkg::ACS_DONE: begin
                nxt_ctrl[acs_pkg::GO_BIT] = 1'b0;
                nxt_flag = 1'b1;
                if (cfg_ff[acs_pkg::JUSTIFY_BIT]) begin
                    nxt_resh = {6'h00, sample_word[9:8]};
                    nxt_resl = sample_word[7:0];
                end else begin
                    nxt_resh = sample_word[9:2];
                    nxt_resl = {sample_word[1:0], 6'h00};
                end
                nxt_state = acs_pkg::ACS_IDLE;
            end
            default: nxt_state = acs_pkg::ACS_IDLE;
        endcase

        if (rd_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rresp = 2'b00;
            unique case (s_axi_araddr)
                acs_pkg::CTRL_OFF: nxt_rdata = {24'h000000, ctrl_ff};
                acs_pkg::CFG_OFF: nxt_rdata = {24'h000000, cfg_ff};
                acs_pkg::TRIG_OFF: nxt_rdata = {27'h0000000, trig_sel_ff};
                acs_pkg::RESH_OFF: nxt_rdata = {24'h000000, resh_ff};
                acs_pkg::RESL_OFF: nxt_rdata = {24'h000000, resl_ff};
                acs_pkg::STAT_OFF: nxt_rdata = {30'h00000000, irqen_ff, flag_ff};
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = 2'b10;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= acs_pkg::CTRL_RST;
            cfg_ff <= acs_pkg::CFG_RST;
            trig_sel_ff <= acs_pkg::TRIG_RST;
            resh_ff <= 8'h00;
            resl_ff <= 8'h00;
            flag_ff <= 1'b0;
            irqen_ff <= 1'b0;
            state_ff <= acs_pkg::ACS_IDLE;
            cnt_ff <= '0;
            awhave_ff <= 1'b0;
            whave_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= 2'b00;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= 2'b00;
        end else begin
            ctrl_ff <= nxt_ctrl;
            cfg_ff <= nxt_cfg;
            trig_sel_ff <= nxt_trig_sel;
            resh_ff <= nxt_resh;
            resl_ff <= nxt_resl;
            flag_ff <= nxt_flag;
            irqen_ff <= nxt_irqen;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            awhave_ff <= nxt_awhave;
            whave_ff <= nxt_whave;
            awaddr_ff <= nxt_awaddr;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    logic chan_valid;
    always_comb begin
        chan_valid = (ctrl_ff[7:2] <= acs_pkg::CH_PA_LAST)
                     || (ctrl_ff[7:2] >= acs_pkg::CH_PC_FIRST
                         && ctrl_ff[7:2] <= acs_pkg::CH_PC_LAST)
                     || (ctrl_ff[7:2] >= acs_pkg::CH_INT_FIRST);
        if (ext_osc_clock && (ctrl_ff[7:2] == acs_pkg::CH_PA4
                              || ctrl_ff[7:2] == acs_pkg::CH_PA_LAST)) begin
            chan_valid = 1'b0;
        end
    end

    assign s_axi_awready = !awhave_ff;
    assign s_axi_wready = !whave_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign converter_on = ctrl_ff[acs_pkg::ON_BIT];
    assign input_channel_select = ctrl_ff[7:2];
    assign channel_connect = chan_valid && ctrl_ff[acs_pkg::ON_BIT];
    // Hold is closed only while converting and loading the result; idle opens it
    assign sample_hold = (state_ff != acs_pkg::ACS_IDLE);
    assign conversion_complete_flag = flag_ff;
    assign conversion_irq = flag_ff && irqen_ff;

endmodule : acs_sequencer
`default_nettype wire

// file: acs_sequencer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_checker #(
    parameter int CONV_CYCLES = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic ext_osc_clock,
    input wire logic converter_on,
    input wire logic [5:0] input_channel_select,
    input wire logic channel_connect,
    input wire logic sample_hold,
    input wire logic conversion_complete_flag,
    input wire logic conversion_irq
);
    // ==========
    // Busy length counter
    logic [15:0] hold_cnt_ff;
    logic [15:0] nxt_hold_cnt;
    always_comb begin
        nxt_hold_cnt = sample_hold ? hold_cnt_ff + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge aclk) begin
        hold_cnt_ff <= aresetn ? nxt_hold_cnt : 16'h0000;
    end
    // ==========
    // Properties
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Abort clears converter_on too, so it is not a completion
    sequence conv_end;
        $fell(sample_hold) && converter_on;
    endsequence
    sequence pa45_blocked;
        ext_osc_clock && (input_channel_select inside {6'h04, 6'h05});
    endsequence
    // Busy spans the counted cycles plus the result-load cycle
    conv_length_a: assert property (conv_end |-> hold_cnt_ff == 16'(CONV_CYCLES + 1))
        else $error("conversion length wrong");
    hold_bound_a: assert property (sample_hold |-> hold_cnt_ff < 16'(CONV_CYCLES + 1))
        else $error("conversion overran");
    done_flag_a: assert property (conv_end |-> conversion_complete_flag)
        else $error("flag not set at completion");
    off_idle_a: assert property (!converter_on |-> !sample_hold)
        else $error("busy while converter off");
    reset_clear_a: assert property ($rose(aresetn) |-> !converter_on && !sample_hold)
        else $error("state survived reset");
    pa_ext_a: assert property (pa45_blocked |-> !channel_connect)
        else $error("channel 4 or 5 connected on external clock");
    reserved_ch_a: assert property ((input_channel_select inside
        {[6'h06:6'h0F], [6'h16:6'h3A]}) |-> !channel_connect)
        else $error("reserved channel connected");
    legal_ch_a: assert property (converter_on && !ext_osc_clock && (input_channel_select
        inside {[6'h00:6'h05], [6'h10:6'h15], [6'h3B:6'h3F]}) |-> channel_connect)
        else $error("legal channel not connected");
    irq_flag_a: assert property (conversion_irq |-> conversion_complete_flag)
        else $error("irq without flag");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
endmodule : acs_sequencer_checker
`default_nettype wire

// file: acs_trig_model.sv
`timescale 1ns/1ps
`default_nettype none
module acs_trig_model #(
    parameter int PULSE = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic fire,
    input wire logic [4:0] fire_code,
    input wire logic [9:0] level,
    output logic [acs_pkg::NUM_TRIG-1:1] trig_src,
    output logic [9:0] sample_data
);
    logic [3:0] left_ff;
    logic [3:0] nxt_left;
    logic [4:0] code_ff;
    logic [4:0] nxt_code;
    always_comb begin
        nxt_left = left_ff;
        nxt_code = code_ff;
        if (left_ff != 4'h0) begin
            nxt_left = left_ff - 4'h1;
        end else if (fire) begin
            nxt_left = 4'(PULSE);
            nxt_code = fire_code;
        end
    end
    always_ff @(posedge aclk) begin
        left_ff <= aresetn ? nxt_left : 4'h0;
        code_ff <= aresetn ? nxt_code : 5'h00;
    end
    // Reserved codes drive no line
    always_comb begin
        trig_src = '0;
        if (left_ff != 4'h0 && code_ff inside {[5'h01:acs_pkg::TRIG_LAST]}) begin
            trig_src[code_ff] = 1'b1;
        end
    end
    assign sample_data = level;
endmodule : acs_trig_model
`default_nettype wire

// file: test_adc_conversion_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_sequencer;
    localparam int CONV = 8;
    typedef struct packed {logic [5:0] ch; logic ext; logic conn;} acs_row_t;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, sleep_mode = 0, ext_osc_clock = 0, fire = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [4:0] fire_code = 0;
    logic [9:0] level = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic [1:0] r;
    logic [acs_pkg::NUM_TRIG-1:1] trig_src;
    logic [9:0] sample_data;
    logic [5:0] input_channel_select;
    logic converter_on, channel_connect, sample_hold, conversion_complete_flag, conversion_irq;
    int num_errors = 0;
    int total_checks = 0;
    acs_row_t rows [12] = '{'{6'h00, 1'b0, 1'b1}, '{6'h05, 1'b0, 1'b1}, '{6'h06, 1'b0, 1'b0},
        '{6'h0F, 1'b0, 1'b0}, '{6'h10, 1'b0, 1'b1}, '{6'h15, 1'b0, 1'b1}, '{6'h16, 1'b0, 1'b0},
        '{6'h3A, 1'b0, 1'b0}, '{6'h3B, 1'b0, 1'b1}, '{6'h3F, 1'b0, 1'b1}, '{6'h04, 1'b1, 1'b0},
        '{6'h03, 1'b1, 1'b1}};
    always #5 aclk = ~aclk;
    acs_sequencer #(.CONV_CYCLES(CONV)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_src, .sleep_mode, .ext_osc_clock,
        .sample_data, .converter_on, .input_channel_select, .channel_connect, .sample_hold,
        .conversion_complete_flag, .conversion_irq);
    acs_trig_model model_i (.aclk, .aresetn, .fire, .fire_code, .level, .trig_src, .sample_data);
    // ==========
    // Reporting
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_bit
    // ==========
    // Bus and stimulus tasks; handshakes judged mid-cycle, acted on at the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        bit ah, wh, bh;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 40) chk_bit(1'b0, 1'b1);
        if (n == 40) tally_and_finish();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        bit ah, rh;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid;
            v = s_axi_rdata;
            rs = s_axi_rresp;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 40) chk_bit(1'b0, 1'b1);
        if (n == 40) tally_and_finish();
    endtask : rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(d, exp);
    endtask : rd_chk
    task automatic wait_hold(input logic exp, input int lim);
        int n;
        for (n = 0; n < lim && sample_hold !== exp; n++) @(negedge aclk);
        chk_bit(sample_hold, exp);
        // Reaching the level on the last poll is still a success
        if (sample_hold !== exp) tally_and_finish();
    endtask : wait_hold
    task automatic idle_chk(input int k);
        repeat (k) @(negedge aclk);
        chk_bit(sample_hold, 1'b0);
    endtask : idle_chk
    task automatic fire_trig(input logic [4:0] c);
        @(posedge aclk);
        fire_code <= c;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
    endtask : fire_trig
    task automatic convert(input logic j, input logic [9:0] v);
        @(posedge aclk);
        level <= v;
        wr(acs_pkg::CFG_OFF, {24'h0, j, 7'h00});
        wr(acs_pkg::CTRL_OFF, 32'h00000001);
        repeat (4) @(posedge aclk);
        wr(acs_pkg::CTRL_OFF, 32'h00000003);
        rd_chk(acs_pkg::CTRL_OFF, 32'h00000003);
        wait_hold(1'b0, 40);
        rd_chk(acs_pkg::CTRL_OFF, 32'h00000001);
        rd_chk(acs_pkg::RESH_OFF, j ? {30'h0, v[9:8]} : {24'h0, v[9:2]});
        rd_chk(acs_pkg::RESL_OFF, j ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00});
        rd_chk(acs_pkg::STAT_OFF, 32'h00000001);
        chk_bit(conversion_complete_flag, 1'b1);
        wr(acs_pkg::STAT_OFF, 32'h00000003);
        @(negedge aclk);
        chk_bit(conversion_irq, 1'b1);
        wr(acs_pkg::STAT_OFF, 32'h00000000);
        @(negedge aclk);
        chk_bit(conversion_irq | conversion_complete_flag, 1'b0);
    endtask : convert
    // ==========
    // Main sequence
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            @(posedge aclk);
            ext_osc_clock <= rows[i].ext;
            wr(acs_pkg::CTRL_OFF, {24'h0, rows[i].ch, 2'b01});
            @(negedge aclk);
            chk_bit(channel_connect, rows[i].conn);
            chk({26'h0, input_channel_select}, {26'h0, rows[i].ch});
            chk_bit(converter_on, 1'b1);
            rd_chk(acs_pkg::CTRL_OFF, {24'h0, rows[i].ch, 2'b01});
        end
        @(posedge aclk);
        ext_osc_clock <= 1'b0;
        rd_chk(acs_pkg::TRIG_OFF, 32'h00000000);
        rd(8'h18, d, r);
        chk({30'h0, r}, 32'h00000002);
        // Write with low byte lane disabled must leave the register alone
        s_axi_wstrb <= 4'h0;
        wr(acs_pkg::CFG_OFF, 32'h00000080);
        s_axi_wstrb <= 4'hF;
        rd_chk(acs_pkg::CFG_OFF, 32'h00000000);
        convert(1'b1, 10'h2A5);
        convert(1'b0, 10'h35A);
        for (int c = 1; c <= 18; c++) begin
            wr(acs_pkg::TRIG_OFF, 32'(c));
            fire_trig(5'(c == 18 ? 1 : c + 1));
            idle_chk(8);
            fire_trig(5'(c));
            wait_hold(1'b1, 10);
            wait_hold(1'b0, 20);
        end
        wr(acs_pkg::TRIG_OFF, 32'h00000000);
        fire_trig(5'h01);
        idle_chk(8);
        wr(acs_pkg::TRIG_OFF, 32'h00000002);
        @(posedge aclk);
        sleep_mode <= 1'b1;
        fire_trig(5'h02);
        idle_chk(8);
        @(posedge aclk);
        sleep_mode <= 1'b0;
        fire_trig(5'h02);
        wait_hold(1'b1, 10);
        fire_trig(5'h02);
        wait_hold(1'b0, 20);
        idle_chk(8);
        wr(acs_pkg::STAT_OFF, 32'h00000000);
        wr(acs_pkg::CTRL_OFF, 32'h00000003);
        wait_hold(1'b1, 10);
        wr(acs_pkg::CTRL_OFF, 32'h00000000);
        @(negedge aclk);
        chk_bit(sample_hold, 1'b0);
        rd_chk(acs_pkg::STAT_OFF, 32'h00000000);
        wr(acs_pkg::CTRL_OFF, 32'h00000001);
        wr(acs_pkg::CTRL_OFF, 32'h00000003);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(negedge aclk);
        chk_bit(converter_on | sample_hold, 1'b0);
        @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(acs_pkg::CTRL_OFF, 32'h00000000);
        tally_and_finish();
    end
endmodule : test_adc_conversion_sequencer
bind acs_sequencer acs_sequencer_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_i (.aclk, .aresetn,
    .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ext_osc_clock,
    .converter_on, .input_channel_select, .channel_connect, .sample_hold,
    .conversion_complete_flag, .conversion_irq);
`default_nettype wire
